/* File: inc/risb_pkg.sv */
// Purpose: Shared constants and types for the radio interrupt status bank
// Assumes: SPI register numbers are 6-bit, data words are 16-bit
// Notes:   Status bit positions, register numbers and reset values live here
package risb_pkg;

  // Register numbers carried in the SPI header
  localparam logic [5:0] RISB_REG_CCA_CFG  = 6'h06;
  localparam logic [5:0] RISB_REG_MODE     = 6'h07;
  localparam logic [5:0] RISB_REG_CMP1_HI  = 6'h1B;
  localparam logic [5:0] RISB_REG_CMP1_LO  = 6'h1C;
  localparam logic [5:0] RISB_REG_CMP2_HI  = 6'h1D;
  localparam logic [5:0] RISB_REG_CMP2_LO  = 6'h1E;
  localparam logic [5:0] RISB_REG_STATUS   = 6'h24;
  localparam logic [5:0] RISB_REG_TIME_HI  = 6'h26;
  localparam logic [5:0] RISB_REG_TIME_LO  = 6'h27;
  localparam logic [5:0] RISB_REG_MASK     = 6'h3A;
  localparam logic [5:0] RISB_REG_ALT_VAL  = 6'h3B;
  localparam logic [5:0] RISB_REG_ALT_EN   = 6'h3C;
  localparam logic [5:0] RISB_REG_TX_DATA  = 6'h3D;
  localparam logic [5:0] RISB_REG_FIFO_LVL = 6'h3E;

  // Status bit positions
  localparam int RISB_B_PLL     = 15;
  localparam int RISB_B_RAM_TXD = 14;
  localparam int RISB_B_ARB_RXD = 13;
  localparam int RISB_B_ATTN    = 10;
  localparam int RISB_B_DOZE    = 9;
  localparam int RISB_B_CMP1    = 8;
  localparam int RISB_B_RX      = 7;
  localparam int RISB_B_TX      = 6;
  localparam int RISB_B_CCA_END = 5;
  localparam int RISB_B_CMP2    = 2;
  localparam int RISB_B_CCA     = 1;
  localparam int RISB_B_CRC     = 0;
  localparam logic [15:0] RISB_STATUS_USED = 16'hE7E7;

  // Control fields
  localparam int          RISB_CCA_TYPE_POS = 4;
  localparam logic [1:0]  RISB_CCA_TYPE_ED  = 2'h2;
  localparam int          RISB_STRM_POS     = 5;
  localparam int          RISB_CMP_DIS_POS  = 15;
  localparam int          RISB_ALT_EN_POS   = 0;

  // Reset values
  localparam logic [7:0]  RISB_CMP_HI_RST = 8'hFF;
  localparam logic [15:0] RISB_CMP_LO_RST = 16'hFFFF;
  localparam logic [15:0] RISB_MASK_RST   = 16'h0000;
  localparam logic [15:0] RISB_ALT_RST    = 16'h0000;

  // SPI framing
  localparam int RISB_HDR_BITS  = 8;
  localparam int RISB_WORD_BITS = 16;
  localparam int RISB_RD_POS    = 7;

  // Stream transmit buffer
  localparam int RISB_FIFO_DEPTH = 16;
  localparam int RISB_WORD_W     = 16;
  localparam int RISB_LVL_W      = 5;

  typedef struct packed {
    logic ram_addr_err;
    logic arb_busy_err;
    logic strm_tx_done;
    logic strm_rx_done;
    logic pkt_rx_done;
    logic pkt_tx_done;
    logic rx_len_ready;
    logic rx_word_ready;
    logic cca_done;
    logic cca_busy;
    logic crc_ok;
    logic pll_unlocked;
    logic powerup_done;
  } risb_evt_t;

  typedef struct packed {
    logic        dis;
    logic [23:0] value;
  } risb_cmp_t;

  typedef enum logic [1:0] {SPI_IDLE, SPI_HDR, SPI_DATA} risb_spi_t;

endpackage

/* File: logic/risb_sync.sv */
// Purpose: Two-flop synchroniser for a group of pin inputs
// Assumes: Each bit is an independent level
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none
module risb_sync #(
  parameter int W = 4
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] rst_val,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] stage1_r;

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge mclk)
      begin
        if (reset)
        begin
          stage1_r[g] <= rst_val[g];
          sync_out[g] <= rst_val[g];
        end
        else if (clk_en)
        begin
          stage1_r[g] <= async_in[g];
          sync_out[g] <= stage1_r[g];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* File: logic/risb_fifo.sv */
// Purpose: Word FIFO with a registered output stage
// Assumes: Single clock
// Notes:   Output data and valid come straight from flops
`timescale 1ns/1ps
`default_nettype none
module risb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int LW    = 5
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output var  logic [WIDTH-1:0] out_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output logic [LW-1:0]         level
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [LW-1:0]    cnt_r;
  logic             push;
  logic             pop;

  assign in_ready = (cnt_r != LW'(DEPTH));
  assign push     = in_valid && in_ready;
  assign pop      = (cnt_r != '0) && (!out_valid || out_ready);
  assign level    = cnt_r;

  always_ff @(posedge mclk)
  begin
    if (clk_en && push)
      mem[wp_r] <= in_data;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else if (clk_en)
    begin
      if (push)
        wp_r <= wp_r + AW'(1);
      if (pop)
        rp_r <= rp_r + AW'(1);
      cnt_r <= cnt_r + LW'(push) - LW'(pop);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (clk_en)
    begin
      if (pop)
      begin
        out_valid <= 1'b1;
        out_data  <= mem[rp_r];
      end
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: logic/risb_top.sv */
// Purpose: Interrupt status bank of a low-power radio, reached over SPI
// Assumes: Sequencer events arrive as one-cycle pulses on mclk
// Notes:   SPI pins are sampled by mclk, mode 0, header then 16-bit words
// How it works
// - Status read returns bits then clears them
// - Mask gates request; events always recorded
// - Bit 15 shows lock loss, masked
// - Mode 0: bit 14 RAM address overrun
// - Mode 1: bit 14 stream transmit done
// - Mode 0: bit 13 RAM access while busy
// - Mode 1: bit 13 stream receive done
// - Bit 10: attention falling edge or power-up complete
// - Doze compare two match sets bit 9, wakes
// - Bit 8: compare one equals timer
// - Mode 0: bit 7 packet received
// - Mode 1: bit 7 length then word ready
// - Mode 0: bit 6 packet sent
// - Mode 1: bit 6 ready for next word
// - Bit 5: channel assessment finished
// - Bit 2: compare two or alternate match
// - Bit 1: channel busy result
// - Energy detect type holds bit 1 low
// - 24-bit event timer, read in two parts
// - Compare loads on low word write
`timescale 1ns/1ps
`default_nettype none
module risb_top
  import risb_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  input  wire logic                   spi_cs_n,
  input  wire logic                   spi_sclk,
  input  wire logic                   spi_mosi,
  output var  logic                   spi_miso,
  output var  logic                   spi_miso_oe,
  input  wire logic                   attn_n,
  input  wire logic                   timer_tick,
  input  wire logic                   doze_active,
  input  wire risb_pkg::risb_evt_t    evt,
  output var  logic                   irq_n,
  output var  logic                   doze_wake,
  output var  logic [RISB_WORD_W-1:0] tx_word,
  output var  logic                   tx_word_valid,
  input  wire logic                   tx_word_ready
);

  import risb_pkg::*;

  // Synchronised pins
  logic       cs_n_s;
  logic       sclk_s;
  logic       mosi_s;
  logic       attn_n_s;
  logic       sclk_d_r;
  logic       attn_d_r;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       attn_fall;

  risb_sync #(.W(4)) u_sync (
    .mclk     (mclk),
    .reset    (reset),
    .clk_en   (clk_en),
    .rst_val  (4'hB),
    .async_in ({spi_cs_n, spi_sclk, spi_mosi, attn_n}),
    .sync_out ({cs_n_s, sclk_s, mosi_s, attn_n_s})
  );

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sclk_d_r <= 1'b0;
      attn_d_r <= 1'b1;
    end
    else if (clk_en)
    begin
      sclk_d_r <= sclk_s;
      attn_d_r <= attn_n_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_d_r && !cs_n_s;
  assign sclk_fall = !sclk_s && sclk_d_r && !cs_n_s;
  assign attn_fall = !attn_n_s && attn_d_r;

  // Register state
  logic [15:0]          status_r;
  logic [15:0]          mask_r;
  logic [15:0]          alt_val_r;
  logic                 alt_en_r;
  logic                 strm_mode_r;
  logic [1:0]           cca_type_r;
  logic [15:0]          cmp1_hi_r;
  logic [15:0]          cmp2_hi_r;
  risb_cmp_t            cmp1_r;
  risb_cmp_t            cmp2_r;
  logic [23:0]          timer_r;
  logic [15:0]          time_lo_hold_r;
  logic                 boot_r;

  // SPI engine
  risb_spi_t            spi_st_r;
  logic [4:0]           bit_cnt_r;
  logic [15:0]          rx_shift_r;
  logic [15:0]          tx_shift_r;
  logic                 is_read_r;
  logic [5:0]           addr_r;
  logic                 hdr_done;
  logic                 word_done;
  logic                 rd_take;
  logic [5:0]           rd_addr;
  logic                 wr_pulse;
  logic [15:0]          wr_data;
  logic [15:0]          shift_in;

  // Stream transmit FIFO
  logic                 fifo_in_ready;
  logic [RISB_LVL_W-1:0] fifo_level;
  logic                 tx_pop;

  function automatic logic wr_hit(input logic pulse, input logic [5:0] a,
                                  input logic [5:0] reg_no);
    wr_hit = pulse && (a == reg_no);
  endfunction

  assign shift_in  = {rx_shift_r[14:0], mosi_s};
  assign hdr_done  = sclk_rise && (spi_st_r == SPI_HDR)
                     && (bit_cnt_r == 5'(RISB_HDR_BITS - 1));
  assign word_done = sclk_rise && (spi_st_r == SPI_DATA)
                     && (bit_cnt_r == 5'(RISB_WORD_BITS - 1));
  assign rd_take   = (hdr_done && shift_in[RISB_RD_POS]) || (word_done && is_read_r);
  assign rd_addr   = hdr_done ? shift_in[5:0] : addr_r + 6'h01;
  assign wr_pulse  = word_done && !is_read_r;
  assign wr_data   = shift_in;

  function automatic logic [15:0] read_mux(input logic [5:0] a);
    unique case (a)
      RISB_REG_CCA_CFG:  read_mux = 16'(cca_type_r) << RISB_CCA_TYPE_POS;
      RISB_REG_MODE:     read_mux = 16'(strm_mode_r) << RISB_STRM_POS;
      RISB_REG_CMP1_HI:  read_mux = cmp1_hi_r;
      RISB_REG_CMP1_LO:  read_mux = cmp1_r.value[15:0];
      RISB_REG_CMP2_HI:  read_mux = cmp2_hi_r;
      RISB_REG_CMP2_LO:  read_mux = cmp2_r.value[15:0];
      RISB_REG_STATUS:   read_mux = status_r & RISB_STATUS_USED;
      RISB_REG_TIME_HI:  read_mux = {8'h00, timer_r[23:16]};
      RISB_REG_TIME_LO:  read_mux = time_lo_hold_r;
      RISB_REG_MASK:     read_mux = mask_r;
      RISB_REG_ALT_VAL:  read_mux = alt_val_r;
      RISB_REG_ALT_EN:   read_mux = 16'(alt_en_r);
      RISB_REG_FIFO_LVL: read_mux = 16'(fifo_level);
      default:           read_mux = 16'h0000;
    endcase
  endfunction

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      spi_st_r   <= SPI_IDLE;
      bit_cnt_r  <= '0;
      rx_shift_r <= '0;
      is_read_r  <= 1'b0;
      addr_r     <= '0;
    end
    else if (clk_en)
    begin
      if (cs_n_s)
        spi_st_r <= SPI_IDLE;
      else
      begin
        unique case (spi_st_r)
          SPI_IDLE:
          begin
            spi_st_r  <= SPI_HDR;
            bit_cnt_r <= '0;
          end
          SPI_HDR, SPI_DATA:
          begin
            if (sclk_rise)
            begin
              rx_shift_r <= shift_in;
              bit_cnt_r  <= bit_cnt_r + 5'h01;
            end
            if (hdr_done)
            begin
              spi_st_r  <= SPI_DATA;
              bit_cnt_r <= '0;
              is_read_r <= shift_in[RISB_RD_POS];
              addr_r    <= shift_in[5:0];
            end
            else if (word_done)
            begin
              bit_cnt_r <= '0;
              addr_r    <= addr_r + 6'h01;
            end
          end
        endcase
      end
    end
  end

  // Read data out on falling SCLK, held undriven while deselected
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      tx_shift_r  <= '0;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      spi_miso_oe <= !cs_n_s;
      if (rd_take)
        tx_shift_r <= read_mux(rd_addr);
      else if (sclk_fall && (spi_st_r == SPI_DATA) && is_read_r)
      begin
        spi_miso   <= tx_shift_r[15];
        tx_shift_r <= {tx_shift_r[14:0], 1'b0};
      end
    end
  end

  // Control registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      mask_r      <= RISB_MASK_RST;
      alt_val_r   <= RISB_ALT_RST;
      alt_en_r    <= 1'b0;
      strm_mode_r <= 1'b0;
      cca_type_r  <= '0;
    end
    else if (clk_en)
    begin
      if (wr_hit(wr_pulse, addr_r, RISB_REG_MASK))
        mask_r <= wr_data;
      if (wr_hit(wr_pulse, addr_r, RISB_REG_ALT_VAL))
        alt_val_r <= wr_data;
      if (wr_hit(wr_pulse, addr_r, RISB_REG_ALT_EN))
        alt_en_r <= wr_data[RISB_ALT_EN_POS];
      if (wr_hit(wr_pulse, addr_r, RISB_REG_MODE))
        strm_mode_r <= wr_data[RISB_STRM_POS];
      if (wr_hit(wr_pulse, addr_r, RISB_REG_CCA_CFG))
        cca_type_r <= wr_data[RISB_CCA_TYPE_POS +: 2];
    end
  end

  // Comparators take the held high word only when the low word lands
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cmp1_hi_r <= {8'h00, RISB_CMP_HI_RST};
      cmp2_hi_r <= {8'h00, RISB_CMP_HI_RST};
      cmp1_r    <= '{dis: 1'b0, value: {RISB_CMP_HI_RST, RISB_CMP_LO_RST}};
      cmp2_r    <= '{dis: 1'b0, value: {RISB_CMP_HI_RST, RISB_CMP_LO_RST}};
    end
    else if (clk_en)
    begin
      if (wr_hit(wr_pulse, addr_r, RISB_REG_CMP1_HI))
        cmp1_hi_r <= wr_data & 16'h80FF;
      if (wr_hit(wr_pulse, addr_r, RISB_REG_CMP2_HI))
        cmp2_hi_r <= wr_data & 16'h80FF;
      if (wr_hit(wr_pulse, addr_r, RISB_REG_CMP1_LO))
        cmp1_r <= '{dis: cmp1_hi_r[RISB_CMP_DIS_POS],
                    value: {cmp1_hi_r[7:0], wr_data}};
      if (wr_hit(wr_pulse, addr_r, RISB_REG_CMP2_LO))
        cmp2_r <= '{dis: cmp2_hi_r[RISB_CMP_DIS_POS],
                    value: {cmp2_hi_r[7:0], wr_data}};
    end
  end

  // Event timer with a coherent low half for two-part reads
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      timer_r        <= '0;
      time_lo_hold_r <= '0;
    end
    else if (clk_en)
    begin
      if (timer_tick)
        timer_r <= timer_r + 24'h000001;
      if (rd_take && (rd_addr == RISB_REG_TIME_HI))
        time_lo_hold_r <= timer_r[15:0];
      else if (rd_take && (rd_addr == RISB_REG_TIME_LO) && !is_read_r)
        time_lo_hold_r <= timer_r[15:0];
    end
  end

  // Event sources for the status bits
  logic        cmp1_hit;
  logic        cmp2_hit;
  logic        alt_hit;
  logic        status_rd;
  logic [15:0] set_v;

  assign cmp1_hit  = timer_tick && !cmp1_r.dis && (timer_r == cmp1_r.value);
  assign cmp2_hit  = timer_tick && !cmp2_r.dis && (timer_r == cmp2_r.value);
  assign alt_hit   = timer_tick && alt_en_r && (timer_r[15:0] == alt_val_r);
  assign status_rd = rd_take && (rd_addr == RISB_REG_STATUS);
  assign tx_pop    = tx_word_valid && tx_word_ready;

  always_comb
  begin
    set_v                 = '0;
    set_v[RISB_B_PLL]     = evt.pll_unlocked;
    set_v[RISB_B_RAM_TXD] = strm_mode_r ? evt.strm_tx_done
                                        : evt.ram_addr_err;
    set_v[RISB_B_ARB_RXD] = strm_mode_r ? evt.strm_rx_done
                                        : evt.arb_busy_err;
    set_v[RISB_B_ATTN]    = attn_fall || evt.powerup_done || boot_r;
    set_v[RISB_B_DOZE]    = cmp2_hit && doze_active;
    set_v[RISB_B_CMP1]    = cmp1_hit;
    set_v[RISB_B_RX]      = strm_mode_r ? (evt.rx_len_ready || evt.rx_word_ready)
                                        : evt.pkt_rx_done;
    set_v[RISB_B_TX]      = strm_mode_r ? tx_pop
                                        : evt.pkt_tx_done;
    set_v[RISB_B_CCA_END] = evt.cca_done;
    set_v[RISB_B_CMP2]    = cmp2_hit || alt_hit;
  end

  // First cycle after reset release counts as power-up complete
  always_ff @(posedge mclk)
  begin
    if (reset)
      boot_r <= 1'b1;
    else if (clk_en)
      boot_r <= 1'b0;
  end

  // Sticky status: a read clears, a same-cycle event still lands
  always_ff @(posedge mclk)
  begin
    if (reset)
      status_r <= '0;
    else if (clk_en)
    begin
      status_r <= ((status_rd ? 16'h0000 : status_r) | set_v) & RISB_STATUS_USED;
      if (evt.pll_unlocked)
        status_r[RISB_B_PLL] <= 1'b1;
      if (evt.cca_done)
        status_r[RISB_B_CCA] <= evt.cca_busy && (cca_type_r != RISB_CCA_TYPE_ED);
      else if (status_rd)
        status_r[RISB_B_CCA] <= 1'b0;
      if (evt.pkt_rx_done && !strm_mode_r)
        status_r[RISB_B_CRC] <= evt.crc_ok;
      else if (status_rd)
        status_r[RISB_B_CRC] <= 1'b0;
    end
  end

  // Request pin and doze wake-up
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      irq_n     <= 1'b1;
      doze_wake <= 1'b0;
    end
    else if (clk_en)
    begin
      irq_n     <= ~|(status_r & mask_r & RISB_STATUS_USED & ~(status_rd ? 16'hFFFF : 16'h0000));
      doze_wake <= cmp2_hit && doze_active;
    end
  end

  risb_fifo #(
    .WIDTH (RISB_WORD_W),
    .DEPTH (RISB_FIFO_DEPTH),
    .LW    (RISB_LVL_W)
  ) u_tx_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .clk_en    (clk_en),
    .in_data   (wr_data),
    .in_valid  (wr_hit(wr_pulse, addr_r, RISB_REG_TX_DATA)),
    .in_ready  (fifo_in_ready),
    .out_data  (tx_word),
    .out_valid (tx_word_valid),
    .out_ready (tx_word_ready),
    .level     (fifo_level)
  );

  logic unused_ok;
  assign unused_ok = fifo_in_ready;

endmodule
`default_nettype wire

/* File: tb/risb_checker.sv */
// Purpose: Port-level checks for the radio interrupt status bank
// Assumes: clk_en held high; SPI pins pass two sync flops
// Notes:   Bound to risb_top below the module
`timescale 1ns/1ps
`default_nettype none
module risb_checker
  import risb_pkg::*;
(
  input wire logic                   mclk,
  input wire logic                   reset,
  input wire logic                   clk_en,
  input wire logic                   spi_cs_n,
  input wire logic                   spi_sclk,
  input wire logic                   spi_mosi,
  input wire logic                   spi_miso,
  input wire logic                   spi_miso_oe,
  input wire logic                   attn_n,
  input wire logic                   timer_tick,
  input wire logic                   doze_active,
  input wire risb_pkg::risb_evt_t    evt,
  input wire logic                   irq_n,
  input wire logic                   doze_wake,
  input wire logic [RISB_WORD_W-1:0] tx_word,
  input wire logic                   tx_word_valid,
  input wire logic                   tx_word_ready
);
  import risb_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Cycles since anything that may set a status bit or change the mask
  logic [7:0] quiet_r;
  always_ff @(posedge mclk)
  begin
    if (reset || (|evt) || !attn_n || timer_tick || !spi_cs_n
        || (tx_word_valid && tx_word_ready))
      quiet_r <= 8'h00;
    else if (quiet_r != 8'hFF)
      quiet_r <= quiet_r + 8'h01;
  end

  a_oe_when_idle:
    assert property (spi_cs_n [*4] |-> !spi_miso_oe)
    else $error("miso enabled while deselected");
  a_oe_when_sel:
    assert property ((!spi_cs_n) [*5] |-> spi_miso_oe)
    else $error("miso not enabled while selected");
  a_miso_steady_high:
    assert property (spi_sclk [*8] |-> $stable(spi_miso))
    else $error("miso moved while sclk high");
  a_irq_rise_read:
    assert property ($rose(irq_n) |-> !$past(spi_cs_n, 4))
    else $error("request released outside an access");
  a_irq_has_cause:
    assert property ($fell(irq_n) |-> quiet_r < 8'h0C)
    else $error("request raised with no cause");
  a_wake_in_doze:
    assert property (doze_wake |-> $past(doze_active) && $past(timer_tick))
    else $error("doze wake without doze and tick");
  a_wake_one_pulse:
    assert property (doze_wake |=> !doze_wake)
    else $error("doze wake longer than one cycle");
  a_tx_head_held:
    assert property (tx_word_valid && !tx_word_ready |=> tx_word_valid && $stable(tx_word))
    else $error("stream word dropped while stalled");

  c_wake: cover property (doze_wake);
  c_irq: cover property ($fell(irq_n));
  c_pop: cover property (tx_word_valid && tx_word_ready);
endmodule

bind risb_top risb_checker u_risb_checker (.*);
`default_nettype wire

/* File: tb/risb_host_model.sv */
// Purpose: Host SPI master reaching the status bank registers
// Assumes: Mode 0, header then one 16-bit word, SCLK half period 16 mclk
// Notes:   SCLK stands low outside frames; MOSI inverts once released
`timescale 1ns/1ps
`default_nettype none
module risb_host_model (
  input  wire logic mclk,
  output logic      spi_cs_n,
  output logic      spi_sclk,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  initial
  begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end

  task automatic wait_half();
    repeat (16) @(posedge mclk);
  endtask

  // Read data is taken at the edge that raises SCLK
  task automatic xfer(input logic [7:0] hdr, input logic [15:0] wd, output logic [15:0] rd);
    logic [23:0] bits;
    bits = {hdr, wd};
    rd = 16'h0000;
    spi_cs_n <= 1'b0;
    wait_half();
    for (int i = 23; i >= 0; i--)
    begin
      spi_mosi <= bits[i];
      wait_half();
      if (i < 16)
        rd[i] = spi_miso;
      spi_sclk <= 1'b1;
      wait_half();
      spi_sclk <= 1'b0;
    end
    wait_half();
    spi_cs_n <= 1'b1;
    spi_mosi <= ~bits[0];
    wait_half();
  endtask
endmodule
`default_nettype wire

/* File: tb/risb_top_tb_top.sv */
// Purpose: Self-checking bench for the radio interrupt status bank
// Assumes: Host model issues all register accesses
// Notes:   Events are one-cycle pulses; mask all-ones once the first event case is done
`timescale 1ns/1ps
`default_nettype none
module risb_top_tb_top;
  import risb_pkg::*;
  logic        mclk, reset, clk_en, spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe;
  logic        attn_n, timer_tick, doze_active, irq_n, doze_wake, tx_word_valid, tx_word_ready;
  risb_evt_t   evt;
  logic [15:0] tx_word;
  logic [15:0] popped[$];
  int          mismatches, cmp_count, wakes;

  risb_top u_risb_top (.*);
  risb_host_model u_risb_host_model (.*);

  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  always @(posedge mclk)
  begin
    if (doze_wake === 1'b1)
      wakes++;
    if (tx_word_valid === 1'b1 && tx_word_ready === 1'b1)
      popped.push_back(tx_word);
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] r, input logic [15:0] d);
    logic [15:0] unused;
    u_risb_host_model.xfer({2'b00, r}, d, unused);
  endtask

  task automatic rd(input logic [5:0] r, output logic [15:0] d);
    u_risb_host_model.xfer({2'b10, r}, 16'h0000, d);
  endtask

  task automatic st(input logic [15:0] exp);
    logic [15:0] v;
    rd(RISB_REG_STATUS, v);
    chk("status", exp, v);
  endtask

  task automatic tick(input int n);
    repeat (n)
    begin
      timer_tick <= 1'b1;
      @(posedge mclk);
      timer_tick <= 1'b0;
      @(posedge mclk);
    end
    repeat (6) @(posedge mclk);
  endtask

  // Pulse events, check the request level, read status, check release
  task automatic ev(input risb_evt_t e, input logic [15:0] exp, input logic lvl);
    evt <= e;
    @(posedge mclk);
    evt <= 13'h0000;
    repeat (8) @(posedge mclk);
    chk("irq_n", {15'h0000, lvl}, {15'h0000, irq_n});
    st(exp);
    chk("irq_n", 16'h0001, {15'h0000, irq_n});
  endtask

  task automatic timer_case();
    logic [15:0] hi, lo;
    logic [23:0] t, c;
    rd(RISB_REG_TIME_HI, hi);
    rd(RISB_REG_TIME_LO, lo);
    t = {hi[7:0], lo} + 24'h000005;
    tick(5);
    rd(RISB_REG_TIME_HI, hi);
    rd(RISB_REG_TIME_LO, lo);
    chk("time_hi", {8'h00, t[23:16]}, hi);
    chk("time_lo", t[15:0], lo);
    c = t + 24'h000003;
    wr(RISB_REG_CMP1_HI, {8'h00, c[23:16]});
    wr(RISB_REG_CMP1_LO, c[15:0]);
    wr(RISB_REG_CMP1_HI, {8'h80, c[23:16]});
    tick(2);
    st(16'h0000);
    tick(2);
    st(16'h0100);
    c = t + 24'h000006;
    wr(RISB_REG_CMP2_HI, {8'h00, c[23:16]});
    wr(RISB_REG_CMP2_LO, c[15:0]);
    doze_active <= 1'b1;
    wakes = 0;
    tick(3);
    doze_active <= 1'b0;
    chk("wakes", 16'h0001, wakes[15:0]);
    st(16'h0204);
    wr(RISB_REG_CMP2_HI, 16'h8000);
    wr(RISB_REG_CMP2_LO, 16'h0000);
    c = t + 24'h000009;
    wr(RISB_REG_ALT_VAL, c[15:0]);
    wr(RISB_REG_ALT_EN, 16'h0001);
    tick(3);
    st(16'h0004);
    wr(RISB_REG_ALT_EN, 16'h0000);
  endtask

  // Stall the far side, overfill, then drain
  task automatic fifo_case();
    for (int i = 0; i < 18; i++)
      wr(RISB_REG_TX_DATA, 16'hA500 + 16'(i));
    popped.delete();
    tx_word_ready <= 1'b1;
    repeat (60) @(posedge mclk);
    tx_word_ready <= 1'b0;
    chk("pops", 16'h0011, 16'(popped.size()));
    for (int i = 0; i < 17 && i < popped.size(); i++)
      chk("word", 16'hA500 + 16'(i), popped[i]);
    st(16'h0040);
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    logic [15:0] v;
    reset = 1'b1;
    clk_en = 1'b1;
    attn_n = 1'b1;
    timer_tick = 1'b0;
    doze_active = 1'b0;
    evt = 13'h0000;
    tx_word_ready = 1'b0;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("irq_n", 16'h0001, {15'h0000, irq_n});
    st(16'h0400);
    st(16'h0000);
    rd(6'h01, v);
    chk("unmapped", 16'h0000, v);
    ev('{pkt_tx_done: 1'b1, default: 1'b0}, 16'h0040, 1'b1);
    wr(RISB_REG_MASK, 16'hFFFF);
    ev('{pll_unlocked: 1'b1, default: 1'b0}, 16'h8000, 1'b0);
    ev('{ram_addr_err: 1'b1, default: 1'b0}, 16'h4000, 1'b0);
    ev('{arb_busy_err: 1'b1, default: 1'b0}, 16'h2000, 1'b0);
    ev('{pkt_rx_done: 1'b1, crc_ok: 1'b1, default: 1'b0}, 16'h0081, 1'b0);
    ev('{pkt_rx_done: 1'b1, default: 1'b0}, 16'h0080, 1'b0);
    ev('{cca_done: 1'b1, cca_busy: 1'b1, default: 1'b0}, 16'h0022, 1'b0);
    wr(RISB_REG_CCA_CFG, 16'h0020);
    ev('{cca_done: 1'b1, cca_busy: 1'b1, default: 1'b0}, 16'h0020, 1'b0);
    attn_n <= 1'b0;
    ev(13'h0000, 16'h0400, 1'b0);
    attn_n <= 1'b1;
    timer_case();
    wr(RISB_REG_MODE, 16'h0020);
    ev('{strm_tx_done: 1'b1, default: 1'b0}, 16'h4000, 1'b0);
    ev('{strm_rx_done: 1'b1, default: 1'b0}, 16'h2000, 1'b0);
    ev('{rx_len_ready: 1'b1, default: 1'b0}, 16'h0080, 1'b0);
    ev('{rx_word_ready: 1'b1, default: 1'b0}, 16'h0080, 1'b0);
    fifo_case();
    close_out();
  end

  initial
  begin
    repeat (99000) @(posedge mclk);
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
